// *** logic/adic_ctrl.sv ***
// Operation
// RULE1: Master bit set makes the block generate the bit clock and drive its pin; clear means slave.
// RULE2: In slave mode the host supplies the bit clock on the bit clock pin.
// RULE3: The pull-down bit enables the pull-down on the playback data pin while set.
// RULE4: Left source bit feeds the left output from the received left (0) or right (1) word.
// RULE5: Right source bit feeds the right output from received left (0) or right (1), default 1.
// RULE6: The TDM enable bit switches the playback data input to time-division slots.
// RULE7: In TDM the slot bit takes the pair from slot 0 or slot 1.
// RULE8: The boost field applies 0, +6, +12 or (reserved) +18 dB of digital gain.
// RULE9: Frames use the selected format: right-, left-justified, I2S (default) or DSP.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module adic_ctrl (
    // System clock and reset
    input wire logic clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adic_pkg::ADDR_W-1:0] paddr,
    input wire logic [adic_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [adic_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    input wire logic bclk_in,
    output logic bclk_out,
    output logic bclk_oe,
    input wire logic lrclk,
    input wire logic playback_serial_data_pin,
    output logic playback_data_pulldown_enable,
    // Playback samples
    output logic [adic_pkg::WORD_LEN-1:0] dac_left,
    output logic [adic_pkg::WORD_LEN-1:0] dac_right,
    output logic dac_valid
);
    import adic_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Saturating gain

    function automatic logic [WORD_LEN-1:0] apply_boost(
        input logic [WORD_LEN-1:0] sample,
        input logic [BOOST_W-1:0] gain
    );
        logic [WORD_LEN+2:0] wide;
        logic [3:0] top;
        logic [WORD_LEN-1:0] result;
        wide = {{3{sample[WORD_LEN-1]}}, sample} << gain;
        top = wide[WORD_LEN+2:WORD_LEN-1];
        if (&top || ~|top) begin
            result = wide[WORD_LEN-1:0];
        end else if (sample[WORD_LEN-1]) begin
            result = SAMPLE_MIN;
        end else begin
            result = SAMPLE_MAX;
        end
        return result;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers and bus decode

    logic [REG_W-1:0] fmt_reg;
    logic [REG_W-1:0] ctrl_reg;
    logic [REG_W-1:0] pair_count_reg;
    logic [WORD_LEN-1:0] raw_left_reg;
    logic [WORD_LEN-1:0] raw_right_reg;
    logic raw_stb_reg;

    logic hit_fmt, hit_ctrl, hit_count, hit_left, hit_right, mapped;
    logic take, commit, wr_ctrl, wr_fmt;
    logic [REG_W-1:0] wmask;
    logic [DATA_W-1:0] rdata;

    logic bit_clock_master_select;
    logic left_playback_source_select;
    logic right_playback_source_select;
    logic [BOOST_W-1:0] playback_boost_gain;

    always_comb begin
        bit_clock_master_select = ctrl_reg[MASTER_BIT];
        left_playback_source_select = ctrl_reg[LEFT_SRC_BIT];
        right_playback_source_select = ctrl_reg[RIGHT_SRC_BIT];
        playback_boost_gain = ctrl_reg[BOOST_LSB +: BOOST_W];
    end

    always_comb begin
        hit_fmt = paddr == FMT_REG_ADDR;
        hit_ctrl = paddr == CTRL_REG_ADDR;
        hit_count = paddr == COUNT_REG_ADDR;
        hit_left = paddr == LEFT_REG_ADDR;
        hit_right = paddr == RIGHT_REG_ADDR;
        mapped = hit_fmt | hit_ctrl | hit_count | hit_left | hit_right;
        // Access phase, first cycle: answer next cycle
        take = psel & penable & ~pready;
        // Access completes at the edge where pready is seen high
        commit = psel & penable & pready & pwrite;
        wr_ctrl = commit & hit_ctrl;
        wr_fmt = commit & hit_fmt;
        wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    end

    always_comb begin
        rdata = '0;
        if (hit_fmt) begin
            rdata = {16'h0, fmt_reg};
        end else if (hit_ctrl) begin
            rdata = {16'h0, ctrl_reg};
        end else if (hit_count) begin
            rdata = {16'h0, pair_count_reg};
        end else if (hit_left) begin
            rdata = {8'h0, raw_left_reg};
        end else if (hit_right) begin
            rdata = {8'h0, raw_right_reg};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= take;
            pslverr <= take & ~mapped;
            if (take) begin
                prdata <= pwrite ? 32'h0 : rdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= (ctrl_reg & ~(wmask & CTRL_MASK)) |
                        (pwdata[REG_W-1:0] & wmask & CTRL_MASK);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fmt_reg <= FMT_RESET;
        end else if (wr_fmt) begin
            fmt_reg <= (fmt_reg & ~(wmask & FMT_MASK)) |
                       (pwdata[REG_W-1:0] & wmask & FMT_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin controls and bit clock generation

    logic [3:0] div_cnt_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            playback_data_pulldown_enable <= 1'b0;
            bclk_oe <= 1'b0;
        end else begin
            playback_data_pulldown_enable <= ctrl_reg[PULLDOWN_BIT]; // [RULE3]
            bclk_oe <= bit_clock_master_select; // [RULE1]
        end
    end

    // Divider stops low in slave mode so the pin never glitches on handover
    always_ff @(posedge clk) begin
        if (srst || !bit_clock_master_select) begin
            div_cnt_reg <= 4'h0;
            bclk_out <= 1'b0;
        end else if (div_cnt_reg == BCLK_HALF_CYCLES - 4'h1) begin
            div_cnt_reg <= 4'h0;
            bclk_out <= ~bclk_out; // [RULE1]
        end else begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: the pin clock, own or host driven, clocks the receiver

    logic link_rst;
    logic [3:0] link_cfg;
    logic [WORD_LEN-1:0] link_left;
    logic [WORD_LEN-1:0] link_right;
    logic link_toggle;

    adic_sync #(.W(1)) u_link_rst (
        .clk(bclk_in),
        .rst(1'b0),
        .d(srst),
        .q(link_rst)
    );

    // Quasi-static settings; change them only while the link is idle
    adic_sync #(.W(4)) u_link_cfg (
        .clk(bclk_in),
        .rst(link_rst),
        .d({fmt_reg[FMT_LSB +: FMT_W], ctrl_reg[TDM_BIT], ctrl_reg[SLOT_BIT]}),
        .q(link_cfg)
    );

    adic_rx u_rx (
        .bclk(bclk_in), // [RULE2]
        .rst(link_rst),
        .lrclk(lrclk),
        .playback_serial_data_pin(playback_serial_data_pin),
        .serial_frame_format(link_cfg[3:2]), // [RULE9]
        .playback_tdm_enable(link_cfg[1]), // [RULE6]
        .playback_slot_select(link_cfg[0]), // [RULE7]
        .left_word(link_left),
        .right_word(link_right),
        .pair_toggle(link_toggle)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pair crossing: toggle event, words held stable for a whole frame

    logic toggle_sync;
    logic toggle_seen_reg;
    logic pair_event;

    adic_sync #(.W(1)) u_toggle_sync (
        .clk(clk),
        .rst(srst),
        .d(link_toggle),
        .q(toggle_sync)
    );

    assign pair_event = toggle_sync != toggle_seen_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            toggle_seen_reg <= 1'b0;
            raw_stb_reg <= 1'b0;
            raw_left_reg <= '0;
            raw_right_reg <= '0;
        end else begin
            toggle_seen_reg <= toggle_sync;
            raw_stb_reg <= pair_event;
            if (pair_event) begin
                raw_left_reg <= link_left;
                raw_right_reg <= link_right;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pair_count_reg <= '0;
        end else if (raw_stb_reg) begin
            pair_count_reg <= pair_count_reg + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source selection and boost

    logic [WORD_LEN-1:0] left_src;
    logic [WORD_LEN-1:0] right_src;

    always_comb begin
        left_src = left_playback_source_select ? raw_right_reg : raw_left_reg; // [RULE4]
        right_src = right_playback_source_select ? raw_right_reg : raw_left_reg; // [RULE5]
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dac_valid <= 1'b0;
            dac_left <= '0;
            dac_right <= '0;
        end else begin
            dac_valid <= raw_stb_reg;
            if (raw_stb_reg) begin
                dac_left <= apply_boost(left_src, playback_boost_gain); // [RULE8]
                dac_right <= apply_boost(right_src, playback_boost_gain); // [RULE8]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking main_cb @(posedge clk);
    endclocking
    default disable iff (srst);

    AST_MASTER_OE: assert property ( // [RULE1]
        bit_clock_master_select |=> bclk_oe)
        else $error("bit clock pin not driven in master mode");
    AST_SLAVE_QUIET: assert property ( // [RULE1]
        !bit_clock_master_select |=> !bclk_oe && !bclk_out)
        else $error("bit clock pin active in slave mode");
    AST_BCLK_HALF: assert property ( // [RULE1]
        bit_clock_master_select && $changed(bclk_out)
        |-> $past(div_cnt_reg) == BCLK_HALF_CYCLES - 4'h1)
        else $error("bit clock half period wrong");
    AST_PULLDOWN: assert property ( // [RULE3]
        wr_ctrl && pstrb[0] |=> ##1
        playback_data_pulldown_enable == $past(pwdata[PULLDOWN_BIT], 2))
        else $error("pull-down does not follow written bit");
    AST_LEFT_SRC: assert property ( // [RULE4]
        dac_valid |-> dac_left == apply_boost(
            $past(ctrl_reg[LEFT_SRC_BIT]) ? $past(raw_right_reg) : $past(raw_left_reg),
            $past(playback_boost_gain)))
        else $error("left output from wrong source");
    AST_RIGHT_SRC: assert property ( // [RULE5]
        dac_valid |-> dac_right == apply_boost(
            $past(ctrl_reg[RIGHT_SRC_BIT]) ? $past(raw_right_reg) : $past(raw_left_reg),
            $past(playback_boost_gain)))
        else $error("right output from wrong source");
    AST_BOOST_12DB: assert property ( // [RULE8]
        raw_stb_reg && playback_boost_gain == BOOST_12DB &&
        !left_playback_source_select && raw_left_reg == 24'h000100
        |=> dac_left == 24'h000400)
        else $error("12 dB boost wrong");
    AST_BOOST_SAT: assert property ( // [RULE8]
        raw_stb_reg && playback_boost_gain == BOOST_18DB &&
        !left_playback_source_select && raw_left_reg == SAMPLE_MAX
        |=> dac_left == SAMPLE_MAX)
        else $error("boost does not saturate");
    AST_VALID_PAIR: assert property (
        pair_event |=> ##1 dac_valid ##1 !dac_valid)
        else $error("pair not presented as one pulse");
    AST_READY_PULSE: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not a single cycle");
endmodule

// *** logic/adic_pkg.sv ***
package adic_pkg;
    // Bus and data widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int WORD_LEN = 24;
    localparam int CNT_W = 7;
    localparam int FMT_W = 2;
    localparam int BOOST_W = 2;

    // Register indexes and byte addresses
    localparam logic [7:0] FMT_REG_IDX = 8'h70;
    localparam logic [7:0] CTRL_REG_IDX = 8'h73;
    localparam logic [7:0] COUNT_REG_IDX = 8'h74;
    localparam logic [7:0] LEFT_REG_IDX = 8'h75;
    localparam logic [7:0] RIGHT_REG_IDX = 8'h76;
    localparam logic [ADDR_W-1:0] FMT_REG_ADDR = {2'h0, FMT_REG_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] CTRL_REG_ADDR = {2'h0, CTRL_REG_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] COUNT_REG_ADDR = {2'h0, COUNT_REG_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] LEFT_REG_ADDR = {2'h0, LEFT_REG_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] RIGHT_REG_ADDR = {2'h0, RIGHT_REG_IDX, 2'h0};

    // Field positions
    localparam int MASTER_BIT = 14;
    localparam int PULLDOWN_BIT = 7;
    localparam int LEFT_SRC_BIT = 6;
    localparam int RIGHT_SRC_BIT = 5;
    localparam int SLOT_BIT = 4;
    localparam int TDM_BIT = 3;
    localparam int BOOST_LSB = 0;
    localparam int FMT_LSB = 8;

    // Reset values and writable bits
    localparam logic [REG_W-1:0] CTRL_RESET = 16'h0020;
    localparam logic [REG_W-1:0] CTRL_MASK = 16'h40fb;
    localparam logic [REG_W-1:0] FMT_RESET = 16'h0200;
    localparam logic [REG_W-1:0] FMT_MASK = 16'h0300;

    // Frame formats
    localparam logic [FMT_W-1:0] FMT_RJ = 2'h0;
    localparam logic [FMT_W-1:0] FMT_LJ = 2'h1;
    localparam logic [FMT_W-1:0] FMT_I2S = 2'h2;
    localparam logic [FMT_W-1:0] FMT_DSP = 2'h3;

    // Boost codes
    localparam logic [BOOST_W-1:0] BOOST_0DB = 2'h0;
    localparam logic [BOOST_W-1:0] BOOST_6DB = 2'h1;
    localparam logic [BOOST_W-1:0] BOOST_12DB = 2'h2;
    localparam logic [BOOST_W-1:0] BOOST_18DB = 2'h3;
    localparam logic [WORD_LEN-1:0] SAMPLE_MAX = 24'h7fffff;
    localparam logic [WORD_LEN-1:0] SAMPLE_MIN = 24'h800000;

    // Frame timing in bit clocks
    localparam int FRAME_DELAY = 1;
    localparam int SLOT_SPAN = 2 * WORD_LEN;

    // Bit clock generation
    localparam int CLK_PERIOD_NS = 40;
    localparam int BCLK_HALF_NS = 80;
    localparam int BCLK_HALF_INT = (BCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] BCLK_HALF_CYCLES = 4'((BCLK_HALF_INT < 1) ? 1 : BCLK_HALF_INT);
endpackage

// *** logic/adic_sync.sv ***
`timescale 1ns/1ps
module adic_sync #(
    parameter int W = 1
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// *** logic/adic_rx.sv ***
`timescale 1ns/1ps
module adic_rx (
    // Link clock and reset
    input wire logic bclk,
    input wire logic rst,
    // Serial frame
    input wire logic lrclk,
    input wire logic playback_serial_data_pin,
    // Configuration in this domain
    input wire logic [adic_pkg::FMT_W-1:0] serial_frame_format,
    input wire logic playback_tdm_enable,
    input wire logic playback_slot_select,
    // Received pair
    output logic [adic_pkg::WORD_LEN-1:0] left_word,
    output logic [adic_pkg::WORD_LEN-1:0] right_word,
    output logic pair_toggle
);
    import adic_pkg::*;

    logic lr_prev_reg;
    logic [CNT_W-1:0] idx_reg;
    logic [CNT_W-1:0] idx_next;
    logic [WORD_LEN-1:0] shift_reg;
    logic [WORD_LEN-1:0] shift_next;
    logic [WORD_LEN-1:0] left_part_reg;
    logic [WORD_LEN-1:0] word;
    logic lr_edge, pair_mode, frame_start, left_is_high, left_done, right_done;
    logic [CNT_W-1:0] delay, offset, left_end, right_end;

    always_comb begin
        lr_edge = lrclk != lr_prev_reg;
        pair_mode = playback_tdm_enable || serial_frame_format == FMT_DSP; // [RULE6]
        frame_start = pair_mode ? (lrclk & ~lr_prev_reg) : lr_edge;
        delay = (serial_frame_format[1]) ? CNT_W'(FRAME_DELAY) : 7'h0; // [RULE9]
        offset = delay + ((playback_tdm_enable & playback_slot_select) ?
                 CNT_W'(SLOT_SPAN) : 7'h0); // [RULE7]
        left_end = offset + CNT_W'(WORD_LEN - 1);
        right_end = left_end + CNT_W'(WORD_LEN);
        idx_next = frame_start ? 7'h0 : ((&idx_reg) ? idx_reg : idx_reg + 7'h1);
        shift_next = {shift_reg[WORD_LEN-2:0], playback_serial_data_pin};
        left_is_high = serial_frame_format != FMT_I2S;
        word = shift_next;
        if (pair_mode) begin
            left_done = idx_next == left_end;
            right_done = idx_next == right_end;
        end else if (serial_frame_format == FMT_RJ) begin
            // Word ends at the select edge; current bit is the next word
            word = shift_reg;
            left_done = lr_edge & lr_prev_reg;
            right_done = lr_edge & ~lr_prev_reg;
        end else begin
            left_done = idx_next == left_end && lrclk == left_is_high; // [RULE9]
            right_done = idx_next == left_end && lrclk != left_is_high;
        end
    end

    always_ff @(posedge bclk) begin
        if (rst) begin
            // Idle frame clock is high: no false edge after reset
            lr_prev_reg <= 1'b1;
            idx_reg <= '1;
            shift_reg <= '0;
        end else begin
            lr_prev_reg <= lrclk;
            idx_reg <= idx_next;
            shift_reg <= shift_next;
        end
    end

    always_ff @(posedge bclk) begin
        if (rst) begin
            left_part_reg <= '0;
            left_word <= '0;
            right_word <= '0;
            pair_toggle <= 1'b0;
        end else begin
            if (left_done) begin
                left_part_reg <= word;
            end
            if (right_done) begin
                left_word <= left_part_reg;
                right_word <= word;
                pair_toggle <= ~pair_toggle;
            end
        end
    end

    default clocking rx_cb @(posedge bclk);
    endclocking
    default disable iff (rst);

    AST_TDM_SLOT0: assert property ( // [RULE6]
        right_done && playback_tdm_enable && !playback_slot_select &&
        serial_frame_format[1] |-> idx_next == CNT_W'(2 * WORD_LEN))
        else $error("slot 0 right word ended at wrong bit");
    AST_TDM_SLOT1: assert property ( // [RULE7]
        right_done && playback_tdm_enable && playback_slot_select &&
        serial_frame_format[1] |-> idx_next == CNT_W'(4 * WORD_LEN))
        else $error("slot 1 right word ended at wrong bit");
    AST_I2S_LEFT: assert property ( // [RULE9]
        left_done && !playback_tdm_enable && serial_frame_format == FMT_I2S
        |-> !lrclk && idx_next == CNT_W'(WORD_LEN))
        else $error("i2s left word misplaced");
endmodule

// *** tb/adic_host.sv ***
`timescale 1ns/1ps
module adic_host (
    // Pin state
    input wire logic pd,
    // Serial frame
    output logic bclk,
    output logic lrclk,
    output logic sdata
);
    logic run;
    logic drive;
    logic bit_q;

    // Bit clock runs only while a frame or reset needs it, stops low
    initial begin
        run = 1'b1;
        bclk = 1'b0;
        lrclk = 1'b1;
        drive = 1'b0;
        bit_q = 1'b0;
        #7;
        forever begin
            #24;
            if (run || bclk) begin
                bclk = ~bclk;
            end
        end
    end

    // Released line: pulled low, or else the inverse of the last bit
    assign sdata = drive ? bit_q : (pd ? 1'b0 : ~bit_q);

    task automatic put(input logic lr, input logic b);
        @(negedge bclk);
        lrclk = lr;
        bit_q = b;
        drive = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////
    task automatic send(input logic tdm, input logic [95:0] bits);
        int k;
        run = 1'b1;
        @(negedge bclk);
        lrclk = ~tdm;
        repeat (3) @(negedge bclk);
        if (tdm) begin
            put(1'b1, 1'b0);
            for (k = 95; k >= 0; k--) put(1'b1, bits[k]);
        end else begin
            put(1'b0, 1'b0);
            for (k = 95; k >= 72; k--) put(1'b0, bits[k]);
            put(1'b1, 1'b0);
            for (k = 71; k >= 48; k--) put(1'b1, bits[k]);
        end
        @(negedge bclk);
        drive = 1'b0;
        @(posedge bclk);
        run = 1'b0;
    endtask
endmodule

// *** tb/audio_dac_interface_control_test.sv ***
`timescale 1ns/1ps
module audio_dac_interface_control_test;
    import adic_pkg::*;
    logic clk, srst, psel, penable, pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic pready, pslverr, e, bclk_out, bclk_oe, host_bclk, lrclk, sdata, pd, dac_valid;
    logic [WORD_LEN-1:0] dac_left, dac_right;
    wire logic bclk_pin = bclk_oe ? bclk_out : host_bclk;
    int bad_count, n_compared;

    adic_ctrl dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bclk_in(bclk_pin), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
        .lrclk(lrclk), .playback_serial_data_pin(sdata), .playback_data_pulldown_enable(pd),
        .dac_left(dac_left), .dac_right(dac_right), .dac_valid(dac_valid));
    adic_host host (.pd(pd), .bclk(host_bclk), .lrclk(lrclk), .sdata(sdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        chk("apb wait", n, 2);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic get_pair();
        int n;
        n = 0;
        while (dac_valid !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk("dac_valid", dac_valid, 1);
    endtask

    function automatic logic [23:0] boost(input logic [23:0] s, input int sh);
        logic signed [31:0] v;
        v = $signed({{8{s[23]}}, s}) <<< sh;
        if (v > 32'sh7fffff) return 24'h7fffff;
        if (v < -32'sh800000) return 24'h800000;
        return v[23:0];
    endfunction

    ////////////////////////////////////////////////////////////
    task automatic test_reset();
        apb(1'b0, CTRL_REG_ADDR, 32'h0);
        chk("ctrl reset", q, 32'h0020);
        chk("mapped no err", e, 0);
        apb(1'b0, FMT_REG_ADDR, 32'h0);
        chk("format reset", q, 32'h0200);
        apb(1'b0, 12'h000, 32'h0);
        chk("unmapped err", e, 1);
        chk("unmapped data", q, 0);
        chk("slave at reset", bclk_oe, 0);
    endtask

    task automatic test_pins();
        int t;
        logic prev;
        apb(1'b1, CTRL_REG_ADDR, 32'h00a0);
        repeat (3) @(posedge clk);
        chk("pulldown on", pd, 1);
        apb(1'b1, CTRL_REG_ADDR, 32'h4020);
        repeat (4) @(posedge clk);
        chk("pulldown off", pd, 0);
        chk("master oe", bclk_oe, 1);
        t = 0;
        prev = bclk_out;
        repeat (16) begin
            @(posedge clk);
            if (bclk_out !== prev) t++;
            prev = bclk_out;
        end
        chk("bclk toggles", t, 8);
        apb(1'b1, CTRL_REG_ADDR, 32'h0020);
        repeat (4) @(posedge clk);
        chk("slave oe", bclk_oe, 0);
    endtask

    task automatic test_paths();
        logic [23:0] l, r;
        logic [31:0] c;
        l = 24'h180000;
        r = 24'he00000;
        for (int i = 0; i < 4; i++) begin
            c = {25'h0, i[0], i[1], 3'h0, 2'(i)};
            apb(1'b1, CTRL_REG_ADDR, c);
            apb(1'b0, CTRL_REG_ADDR, 32'h0);
            chk("ctrl readback", q, c);
            host.send(1'b0, {l, r, 48'h0});
            get_pair();
            chk("left out", dac_left, boost(i[0] ? r : l, i));
            chk("right out", dac_right, boost(i[1] ? r : l, i));
        end
    endtask

    task automatic test_tdm();
        apb(1'b1, CTRL_REG_ADDR, 32'h0038);
        host.send(1'b1, {24'h111111, 24'h222222, 24'h0abcde, 24'h0fedcb});
        get_pair();
        chk("tdm left", dac_left, 24'h0abcde);
        chk("tdm right", dac_right, 24'h0fedcb);
        apb(1'b0, COUNT_REG_ADDR, 32'h0);
        chk("pair count", q, 5);
    endtask

    task automatic test_boost();
        apb(1'b1, CTRL_REG_ADDR, 32'h0022);
        host.send(1'b0, {24'h000100, 24'h7fffff, 48'h0});
        get_pair();
        chk("boost12 left", dac_left, boost(24'h000100, 2));
        chk("boost12 right", dac_right, boost(24'h7fffff, 2));
        apb(1'b1, CTRL_REG_ADDR, 32'h0023);
        host.send(1'b0, {24'h7fffff, 24'h000100, 48'h0});
        get_pair();
        chk("boost18 left", dac_left, boost(24'h7fffff, 3));
        chk("boost18 right", dac_right, boost(24'h000100, 3));
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h3;
        bad_count = 0;
        n_compared = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        host.run = 1'b0;
        test_reset();
        test_pins();
        test_paths();
        test_tdm();
        test_boost();
        stop_test();
    end

    initial begin
        #500000;
        bad_count++;
        $display("watchdog expired");
        stop_test();
    end
endmodule
